// file: hw/iser_top.v
// interrupt status, enable, acknowledge and master control registers
`timescale 1ns/1ps
`include "iser_regs.vh"

module iser_top #(
  parameter NUM_INPUTS      = 32,
  parameter HAS_PENDING     = 1,
  parameter HAS_SET_ENABLES = 1
) (
  input  wire                      ref_clk,
  input  wire                      rstn,
  input  wire [NUM_INPUTS-1:0]     hw_intr,
  input  wire [`ISER_ADDR_W-1:0]   bus_addr,
  input  wire                      bus_wr,
  input  wire                      bus_rd,
  input  wire [`ISER_DATA_W-1:0]   bus_wdata,
  output reg  [`ISER_DATA_W-1:0]   bus_rdata_q,
  output reg                       bus_rvalid_q,
  output reg                       bus_wack_q,
  output reg                       irq_q
);

  // ****************************************************************
  // input synchroniser
  // ****************************************************************
  reg [NUM_INPUTS-1:0] hw_meta_q;
  reg [NUM_INPUTS-1:0] hw_sync_q;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hw_meta_q <= {NUM_INPUTS{1'b0}};
      hw_sync_q <= {NUM_INPUTS{1'b0}};
    end else begin
      hw_meta_q <= hw_intr;
      hw_sync_q <= hw_meta_q;
    end
  end

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire [`ISER_ADDR_W-1:0] word_addr;
  wire                    hit_status;
  wire                    hit_pending;
  wire                    hit_enable;
  wire                    hit_ack;
  wire                    hit_set_en;
  wire                    hit_master;

  // low two address bits do not select; every location is a word
  assign word_addr   = {bus_addr[`ISER_ADDR_W-1:2], 2'b00};
  assign hit_status  = (word_addr == `ISER_OFF_STATUS);
  assign hit_pending = (word_addr == `ISER_OFF_PENDING);
  assign hit_enable  = (word_addr == `ISER_OFF_ENABLE);
  assign hit_ack     = (word_addr == `ISER_OFF_ACK);
  assign hit_set_en  = (word_addr == `ISER_OFF_SET_EN);
  assign hit_master  = (word_addr == `ISER_OFF_MASTER);

  wire wr_status;
  wire wr_enable;
  wire wr_ack;
  wire wr_set_en;
  wire wr_master;

  assign wr_status = bus_wr && hit_status;
  assign wr_enable = bus_wr && hit_enable;
  assign wr_ack    = bus_wr && hit_ack;
  assign wr_master = bus_wr && hit_master;
  assign wr_set_en = bus_wr && hit_set_en && (HAS_SET_ENABLES != 0);

  // ****************************************************************
  // master control
  // ****************************************************************
  reg me_q;
  reg hie_q;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      me_q  <= `ISER_RST_ME;
      hie_q <= `ISER_RST_HIE;
    end else begin
      if (wr_master) begin
        me_q <= bus_wdata[`ISER_MC_ME_BIT];
      end
      if (wr_master && bus_wdata[`ISER_MC_HIE_BIT]) begin
        hie_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // per-input status and enable cells
  // ****************************************************************
  wire [`ISER_DATA_W-1:0] status_w;
  wire [`ISER_DATA_W-1:0] enable_w;
  wire                    sw_write_ok;

  // software writes to the status register blocked after hardware enable
  assign sw_write_ok = wr_status && !hie_q;

  genvar gi;
  generate
    for (gi = 0; gi < `ISER_DATA_W; gi = gi + 1) begin : g_bit
      if (gi < NUM_INPUTS) begin : g_used
        iser_bit u_bit (
          .ref_clk   (ref_clk),
          .rstn      (rstn),
          .hw_active (hw_sync_q[gi]),
          .hw_sel    (hie_q),
          .sw_set    (sw_write_ok && bus_wdata[gi]),
          .ack       (wr_ack && bus_wdata[gi]),
          .en_wr     (wr_enable),
          .en_wdata  (bus_wdata[gi]),
          .en_set    (wr_set_en && bus_wdata[gi]),
          .status_q  (status_w[gi]),
          .enable_q  (enable_w[gi])
        );
      end else begin : g_unused
        assign status_w[gi] = 1'b0;
        assign enable_w[gi] = 1'b0;
      end
    end
  endgenerate

  // ****************************************************************
  // pending view
  // ****************************************************************
  wire [`ISER_DATA_W-1:0] pending_w;

  generate
    if (HAS_PENDING != 0) begin : g_pending
      assign pending_w = status_w & enable_w;
    end else begin : g_no_pending
      assign pending_w = `ISER_RST_PENDING;
    end
  endgenerate

  // ****************************************************************
  // interrupt request output
  // ****************************************************************
  wire irq_d;

  assign irq_d = me_q && (|(status_w & enable_w));

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  reg [`ISER_DATA_W-1:0] rdata_d;

  always @* begin
    rdata_d = `ISER_RST_RDATA;
    if (hit_status) begin
      rdata_d = status_w;
    end else if (hit_pending) begin
      rdata_d = pending_w;
    end else if (hit_enable) begin
      rdata_d = enable_w;
    end else if (hit_master) begin
      rdata_d[`ISER_MC_ME_BIT]  = me_q;
      rdata_d[`ISER_MC_HIE_BIT] = hie_q;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bus_rdata_q  <= `ISER_RST_RDATA;
      bus_rvalid_q <= 1'b0;
      bus_wack_q   <= 1'b0;
    end else begin
      bus_rvalid_q <= bus_rd;
      bus_wack_q   <= bus_wr;
      if (bus_rd) begin
        bus_rdata_q <= rdata_d;
      end
    end
  end

endmodule // iser_top

// file: hw/iser_regs.vh
// register map, field positions and reset values of the interrupt registers
`ifndef ISER_REGS_VH
`define ISER_REGS_VH

// ****************************************************************
// bus geometry
// ****************************************************************
`define ISER_DATA_W        32
`define ISER_ADDR_W        5

// ****************************************************************
// byte offsets from the block base
// ****************************************************************
`define ISER_OFF_STATUS    5'h00
`define ISER_OFF_PENDING   5'h04
`define ISER_OFF_ENABLE    5'h08
`define ISER_OFF_ACK       5'h0c
`define ISER_OFF_SET_EN    5'h10
`define ISER_OFF_MASTER    5'h1c

// ****************************************************************
// master control fields
// ****************************************************************
`define ISER_MC_ME_BIT     0
`define ISER_MC_HIE_BIT    1

// ****************************************************************
// reset values
// ****************************************************************
`define ISER_RST_STATUS    32'h0000_0000
`define ISER_RST_ENABLE    32'h0000_0000
`define ISER_RST_PENDING   32'h0000_0000
`define ISER_RST_RDATA     32'h0000_0000
`define ISER_RST_ME        1'b0
`define ISER_RST_HIE       1'b0

`endif

// file: hw/iser_bit.v
// one interrupt input: sticky status flag and its enable bit
`timescale 1ns/1ps
`include "iser_regs.vh"

module iser_bit (
  input  wire ref_clk,
  input  wire rstn,
  input  wire hw_active,
  input  wire hw_sel,
  input  wire sw_set,
  input  wire ack,
  input  wire en_wr,
  input  wire en_wdata,
  input  wire en_set,
  output reg  status_q,
  output reg  enable_q
);

  reg status_d;
  reg enable_d;

  // ****************************************************************
  // next state
  // ****************************************************************
  always @* begin
    status_d = status_q;
    if (ack) begin
      status_d = 1'b0;
    end
    if ((hw_sel && hw_active) || (!hw_sel && sw_set)) begin
      status_d = 1'b1;
    end
    enable_d = enable_q;
    if (en_wr) begin
      enable_d = en_wdata;
    end else if (en_set) begin
      enable_d = 1'b1;
    end
  end

  // ****************************************************************
  // state
  // ****************************************************************
  // cleared on reset
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= 1'b0;
      enable_q <= 1'b0;
    end else begin
      status_q <= status_d;
      enable_q <= enable_d;
    end
  end

endmodule // iser_bit

// file: dv/iser_chk.sv
// assertion checker for the interrupt register block
`timescale 1ns/1ps
`include "iser_regs.vh"
module iser_chk #(parameter NUM_INPUTS = 32) (
  input wire                  ref_clk,
  input wire                  rstn,
  input wire [NUM_INPUTS-1:0] hw_intr,
  input wire [4:0]            bus_addr,
  input wire                  bus_wr,
  input wire                  bus_rd,
  input wire [31:0]           bus_wdata,
  input wire [31:0]           bus_rdata_q,
  input wire                  bus_rvalid_q,
  input wire                  bus_wack_q,
  input wire                  irq_q
);
  localparam [32:0] ONES = (33'h1 << NUM_INPUTS) - 33'h1;
  wire [31:0] msk = ONES[31:0];
  reg         me_q;
  reg         hie_q;
  reg  [31:0] en_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ********************
  // shadow of master control and enable mask
  // ********************
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      me_q <= 1'b0;
      hie_q <= 1'b0;
      en_q <= 32'h0;
    end else if (bus_wr) begin
      if (bus_addr == `ISER_OFF_ENABLE)
        en_q <= bus_wdata & msk;
      if (bus_addr == `ISER_OFF_SET_EN)
        en_q <= en_q | (bus_wdata & msk);
      if (bus_addr == `ISER_OFF_MASTER) begin
        me_q <= bus_wdata[0];
        hie_q <= hie_q | bus_wdata[1];
      end
    end
  end
  ack_reads_zero_a: assert property (bus_rd && (bus_addr == `ISER_OFF_ACK ||
    bus_addr == `ISER_OFF_SET_EN) |=> bus_rdata_q == 32'h0)
    else $error("write-only location read nonzero");
  free_bits_zero_a: assert property (bus_rd && bus_addr <= `ISER_OFF_ENABLE
    |=> (bus_rdata_q & ~msk) == 32'h0) else $error("missing input bit set");
  pend_masked_a: assert property (bus_rd && bus_addr == `ISER_OFF_PENDING
    |=> (bus_rdata_q & ~en_q) == 32'h0) else $error("pending outside mask");
  enable_readback_a: assert property ((bus_wr && bus_addr == `ISER_OFF_ENABLE)
    ##2 (bus_rd && bus_addr == `ISER_OFF_ENABLE) |=> bus_rdata_q == en_q)
    else $error("enable readback wrong");
  master_readback_a: assert property (bus_rd && bus_addr == `ISER_OFF_MASTER
    |=> bus_rdata_q == {30'h0, hie_q, me_q}) else $error("master readback");
  irq_me_gate_a: assert property (!me_q |=> !irq_q)
    else $error("irq without master enable");
  irq_en_gate_a: assert property (en_q == 32'h0 |=> !irq_q)
    else $error("irq with all inputs masked");
  reset_quiet_a: assert property ($rose(rstn) |-> !irq_q && !bus_rvalid_q)
    else $error("outputs active after reset");
  write_answer_a: assert property (bus_wr |=> bus_wack_q)
    else $error("write not answered");
  write_quiet_a: assert property (!bus_wr |=> !bus_wack_q)
    else $error("write answer without write");
  read_answer_a: assert property (bus_rd |=> bus_rvalid_q)
    else $error("read not answered");
  cover property ($rose(irq_q));
  cover property (bus_wr && bus_addr == `ISER_OFF_ACK);
  cover property (hie_q && bus_rd && bus_addr == `ISER_OFF_STATUS);
endmodule // iser_chk
bind iser_top iser_chk #(.NUM_INPUTS(NUM_INPUTS)) chk_u (.ref_clk(ref_clk),
  .rstn(rstn), .hw_intr(hw_intr), .bus_addr(bus_addr), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q),
  .bus_rvalid_q(bus_rvalid_q), .bus_wack_q(bus_wack_q), .irq_q(irq_q));

// file: dv/iser_cpu.sv
// processor model issuing register reads and writes
`timescale 1ns/1ps
module iser_cpu (
  input  wire        ref_clk,
  output reg  [4:0]  bus_addr,
  output reg         bus_wr,
  output reg         bus_rd,
  output reg  [31:0] bus_wdata
);
  logic [31:0] exp_q[$];
  initial begin
    bus_addr = 5'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 32'h0;
  end
  // released write data and read address are inverted so stale values never look valid
  task automatic wr(input [4:0] a, input [31:0] d);
    @(posedge ref_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    bus_wdata <= ~d;
  endtask
  task automatic rd(input [4:0] a, input [31:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    bus_addr <= ~a;
  endtask
endmodule // iser_cpu

// file: dv/iser_tb_top.sv
// self-checking bench for the interrupt register block
`timescale 1ns/1ps
`include "iser_regs.vh"
module iser_tb_top;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  hw_intr = 8'h0;
  wire  [4:0]  bus_addr;
  wire         bus_wr;
  wire         bus_rd;
  wire  [31:0] bus_wdata;
  wire  [31:0] bus_rdata_q;
  wire         bus_rvalid_q;
  wire         bus_wack_q;
  wire         irq_q;
  int          n_errors = 0;
  int          compares = 0;
  logic [31:0] lf = 32'd75117;
  logic [31:0] st = 32'h0;
  logic [31:0] en = 32'h0;
  logic [4:0]  offs[8] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18,
                           5'h1c};
  iser_cpu cpu_u (.ref_clk(ref_clk), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata));
  iser_top #(.NUM_INPUTS(8)) dut_u (.ref_clk(ref_clk), .rstn(rstn),
    .hw_intr(hw_intr), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q),
    .bus_rvalid_q(bus_rvalid_q), .bus_wack_q(bus_wack_q), .irq_q(irq_q));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task nx;
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task chk_irq(input logic x);
    repeat (3) @(posedge ref_clk);
    #1;
    check({31'h0, irq_q}, {31'h0, x});
  endtask
  task close_out;
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // read answers are matched against the oldest note
  always @(posedge ref_clk) begin
    if (bus_rvalid_q === 1'b1) begin
      if (cpu_u.exp_q.size() == 0)
        n_errors++;
      else
        check(bus_rdata_q, cpu_u.exp_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    close_out;
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    foreach (offs[i]) cpu_u.rd(offs[i], 32'h0);
    for (int i = 0; i < 6; i++) begin
      nx();
      cpu_u.wr(`ISER_OFF_STATUS, lf);
      st |= lf & 32'hff;
      nx();
      cpu_u.wr(`ISER_OFF_ENABLE, lf);
      en = lf & 32'hff;
      nx();
      cpu_u.wr(`ISER_OFF_SET_EN, lf & 32'h0f0f_0f0f);
      en |= lf & 32'h0000_000f;
      cpu_u.rd(`ISER_OFF_STATUS, st);
      cpu_u.rd(`ISER_OFF_ENABLE, en);
      cpu_u.rd(`ISER_OFF_PENDING, st & en);
      nx();
      cpu_u.wr(`ISER_OFF_ACK, lf);
      st &= ~lf;
      cpu_u.rd(`ISER_OFF_STATUS, st);
    end
    cpu_u.wr(`ISER_OFF_STATUS, 32'h5);
    st |= 32'h5;
    cpu_u.wr(`ISER_OFF_MASTER, 32'h1);
    cpu_u.wr(`ISER_OFF_ENABLE, 32'h0);
    cpu_u.rd(`ISER_OFF_ENABLE, 32'h0);
    chk_irq(1'b0);
    cpu_u.rd(`ISER_OFF_STATUS, st);
    cpu_u.wr(`ISER_OFF_SET_EN, 32'h4);
    chk_irq(1'b1);
    cpu_u.wr(`ISER_OFF_MASTER, 32'h0);
    chk_irq(1'b0);
    cpu_u.wr(`ISER_OFF_MASTER, 32'h3);
    chk_irq(1'b1);
    cpu_u.wr(`ISER_OFF_ACK, 32'hff);
    cpu_u.wr(`ISER_OFF_STATUS, 32'hff);
    cpu_u.rd(`ISER_OFF_STATUS, 32'h0);
    chk_irq(1'b0);
    @(posedge ref_clk);
    hw_intr <= 8'h84;
    repeat (5) @(posedge ref_clk);
    hw_intr <= 8'h80;
    chk_irq(1'b1);
    repeat (2) @(posedge ref_clk);
    cpu_u.wr(`ISER_OFF_ACK, 32'h84);
    cpu_u.rd(`ISER_OFF_STATUS, 32'h80);
    chk_irq(1'b0);
    cpu_u.wr(`ISER_OFF_MASTER, 32'h0);
    cpu_u.rd(`ISER_OFF_MASTER, 32'h2);
    repeat (4) @(posedge ref_clk);
    check(32'(cpu_u.exp_q.size()), 32'h0);
    close_out;
  end
endmodule // iser_tb_top
